// >>> dv/adcfe_ctl_model.sv
`timescale 1ns/1ps
module adcfe_ctl_model (
	input wire logic mclk, // System clock
	input wire logic dev_out, // Device read data
	input wire logic dev_oe, // Device drives data line
	output logic bus_clock_pin, // Bus clock
	output logic bus_mode_line, // Bus mode line
	output wire logic bus_data_line // Resolved data line
);
	logic drv;
	// Device wins while enabled
	assign bus_data_line = dev_oe ? dev_out : drv;
	initial
	begin
		bus_clock_pin = 1'b1;
		bus_mode_line = 1'b0;
		drv = 1'b0;
	end
	// Static levels, bus clock held low
	task automatic pins(input logic m, input logic d);
		@(posedge mclk);
		bus_clock_pin <= 1'b0;
		bus_mode_line <= m;
		drv <= d;
	endtask : pins
	// Single wake pulse
	task automatic wake();
		@(posedge mclk);
		bus_clock_pin <= 1'b0;
		repeat (6) @(posedge mclk);
		bus_clock_pin <= 1'b1;
		repeat (6) @(posedge mclk);
	endtask : wake
	// One phase, v[n-1] first; rd releases the line with a toggle
	task automatic frame(input logic m, input int n, input logic [23:0] v,
		input logic rd, output logic [23:0] r);
		r = '0;
		@(posedge mclk);
		bus_mode_line <= m;
		repeat (4) @(posedge mclk);
		for (int i = n - 1; i >= 0; i--)
		begin
			bus_clock_pin <= 1'b0;
			drv <= rd ? ~drv : v[i];
			repeat (6) @(posedge mclk);
			bus_clock_pin <= 1'b1;
			r = {r[22:0], bus_data_line};
			repeat (6) @(posedge mclk);
		end
	endtask : frame
endmodule : adcfe_ctl_model

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	localparam logic [5:0] DEV = adcfe_pkg::DEV_ADDR_DEFAULT;
	logic mclk, sys_rst, strap, mute_pin, chan, csrc, conv;
	logic bclk, bmode, dout, doe, lock, eml, emh, smode, smute;
	wire bdata;
	adcfe_pkg::adcfe_status_t st;
	adcfe_pkg::adcfe_ctrl_t e, ctrl_out;
	logic [23:0] r;
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;

	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	adcfe_top adcfe_top_i (.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1),
		.control_mode_strap(strap), .bus_clock_pin(bclk),
		.bus_mode_line(bmode), .bus_data_line(bdata), .mute_pin(mute_pin),
		.input_channel_select(chan), .clock_source_select(csrc),
		.converter_source_select(conv), .decoder_status(st),
		.bus_data_out(dout), .bus_data_oe(doe), .lock_status(lock),
		.emphasis_status_low(eml), .emphasis_status_high(emh),
		.static_mode(smode), .soft_mute_active(smute), .ctrl_out(ctrl_out));

	adcfe_ctl_model adcfe_ctl_model_i (.mclk(mclk), .dev_out(dout),
		.dev_oe(doe), .bus_clock_pin(bclk), .bus_mode_line(bmode),
		.bus_data_line(bdata));

	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [7:0] rev8(input logic [7:0] b);
		for (int i = 0; i < 8; i++)
			rev8[i] = b[7 - i];
	endfunction : rev8

	task automatic dflt();
		e = '0;
		e.power_on = 1'b1;
		e.converter_source_select = 1'b1;
		e.lock_mute_enable = 1'b1;
	endtask : dflt

	task automatic wr(input logic [5:0] dv, input logic [6:0] a,
		input logic [15:0] d);
		adcfe_ctl_model_i.frame(1'b0, 8, {16'h0, rev8({dv, 2'h2})}, 1'b0, r);
		adcfe_ctl_model_i.frame(1'b1, 24, {1'b0, a, d}, 1'b0, r);
		repeat (8) @(posedge mclk);
	endtask : wr

	task automatic rd(input logic [6:0] a, input logic [23:0] exp);
		adcfe_ctl_model_i.frame(1'b0, 8, {16'h0, rev8({DEV, 2'h2})}, 1'b0, r);
		adcfe_ctl_model_i.frame(1'b1, 8, {16'h0, 1'b1, a}, 1'b0, r);
		adcfe_ctl_model_i.frame(1'b0, 8, {16'h0, rev8({DEV, 2'h3})}, 1'b0, r);
		adcfe_ctl_model_i.frame(1'b1, 24, 24'h0, 1'b1, r);
		chk(r, exp);
	endtask : rd

	task automatic rst();
		@(posedge mclk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask : rst

	// Hang guard
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fail_count++;
			end_of_test();
		end
	end

	initial
	begin
		sys_rst = 1'b1;
		strap = 1'b0;
		mute_pin = 1'b0;
		chan = 1'b0;
		csrc = 1'b0;
		conv = 1'b0;
		st = '0;
		rst();
		dflt();
		chk(ctrl_out, e);
		chk(smute, 1'b1);
		chk(smode, 1'b0);
		@(posedge mclk);
		st <= 10'h19E;
		repeat (8) @(posedge mclk);
		chk(lock, 1'b1);
		chk({emh, eml}, 2'h2);
		adcfe_ctl_model_i.wake();
		wr(DEV, 7'h40, 16'h0003);
		wr(DEV, 7'h7F, 16'h0000);
		chk(ctrl_out, e);
		wr(DEV, 7'h01, 16'h1234);
		e.volume = 6'h34;
		e.bass = 4'h8;
		e.filter_mode = 2'h1;
		e.lock_mute_enable = 1'b0;
		chk(ctrl_out, e);
		chk(smute, 1'b0);
		rd(7'h01, {1'b0, 7'h01, 16'h1234});
		rd(7'h02, {1'b0, 7'h02, 6'h00, st});
		rd(7'h05, {1'b1, 7'h05, 16'h0000});
		wr(DEV ^ 6'h01, 7'h00, 16'h0036);
		chk(ctrl_out, e);
		wr(DEV, 7'h00, 16'h0036);
		e.power_on = 1'b0;
		e.input_channel_select = 1'b1;
		e.clock_source_select = 1'b1;
		e.converter_source_select = 1'b0;
		e.format = 2'h3;
		chk(ctrl_out, e);
		wr(DEV, 7'h01, 16'h4000);
		chk(smute, 1'b1);
		rst();
		dflt();
		chk(ctrl_out, e);
		@(posedge mclk);
		strap <= 1'b1;
		repeat (8) @(posedge mclk);
		chk(smode, 1'b1);
		chk(smute, 1'b0);
		for (int i = 0; i < 4; i++)
		begin
			adcfe_ctl_model_i.pins(i[1], i[0]);
			chan <= i[0];
			csrc <= ~i[0];
			conv <= i[0];
			repeat (8) @(posedge mclk);
			dflt();
			e.format = i[1:0];
			e.input_channel_select = i[0];
			e.clock_source_select = ~i[0];
			e.converter_source_select = i[0];
			chk(ctrl_out, e);
		end
		mute_pin <= 1'b1;
		repeat (8) @(posedge mclk);
		chk(smute, 1'b1);
		mute_pin <= 1'b0;
		repeat (8) @(posedge mclk);
		chk(smute, 1'b0);
		chk(lock, 1'b0);
		st.pcm_detected <= 1'b1;
		repeat (8) @(posedge mclk);
		chk(lock, 1'b1);
		strap <= 1'b0;
		repeat (8) @(posedge mclk);
		chk(smode, 1'b0);
		end_of_test();
	end
endmodule : tb_top

// >>> rtl/adcfe_pin_sync.sv
`timescale 1ns/1ps
module adcfe_pin_sync #(
	parameter int WIDTH = 8
) (
	input wire logic mclk, // System clock
	input wire logic sys_rst, // Synchronous reset, high
	input wire logic clk_en, // Freezes state when low
	input wire logic [WIDTH-1:0] pin_in, // Asynchronous pins
	output logic [WIDTH-1:0] pin_sync // Synchronised pins
);

	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			meta_reg <= '0;
			pin_sync <= '0;
		end
		else if (clk_en)
		begin
			meta_reg <= pin_in;
			pin_sync <= meta_reg;
		end
	end

endmodule : adcfe_pin_sync

// >>> rtl/adcfe_pkg.sv
package adcfe_pkg;

	// Synchroniser depth for every pin that comes from outside mclk
	localparam int SYNC_STAGES = 2;

	// Register indices as carried on the bus (7-bit)
	localparam logic [6:0] REG_SYSTEM = 7'h00;
	localparam logic [6:0] REG_SOUND = 7'h01;
	localparam logic [6:0] REG_STATUS = 7'h02;
	localparam logic [6:0] REG_PLL_INIT = 7'h40;
	localparam logic [6:0] REG_RESTORE = 7'h7F;

	// Values after reset and after a defaults restore
	localparam logic [15:0] SYSTEM_RESET = 16'h0009;
	localparam logic [15:0] SOUND_RESET = 16'hC000;
	localparam logic [15:0] PLL_INIT_RESET = 16'h0000;

	// System register fields
	localparam int SYS_POWER_BIT = 0;
	localparam int SYS_CHAN_BIT = 1;
	localparam int SYS_CLK_BIT = 2;
	localparam int SYS_DAC_BIT = 3;
	localparam int SYS_FMT_LSB = 4;
	localparam int SYS_DEEM_LSB = 6;

	// Sound register fields
	localparam int SND_VOL_LSB = 0;
	localparam int SND_BASS_LSB = 6;
	localparam int SND_TREB_LSB = 10;
	localparam int SND_FILT_LSB = 12;
	localparam int SND_MUTE_BIT = 14;
	localparam int SND_AUTO_BIT = 15;

	// Transfer type field of the address byte, {bit1, bit0}
	localparam logic [1:0] XFER_WRITE = 2'h2;
	localparam logic [1:0] XFER_READ = 2'h3;

	// Device address field, value arbitrary
	localparam logic [5:0] DEV_ADDR_DEFAULT = 6'h06;

	// Bit counter marks within a phase
	localparam logic [4:0] LAST_BYTE_BIT = 5'h07;
	localparam logic [4:0] LAST_DATA_BIT = 5'h17;
	localparam logic [4:0] CNT_MAX = 5'h18;

	typedef enum logic [1:0] {SEL_NONE, SEL_WRITE, SEL_READ} adcfe_sel_t;

	typedef struct packed {
		logic [1:0] clock_accuracy_code;
		logic [1:0] emphasis;
		logic pcm_detected;
		logic [1:0] sample_rate_code;
		logic decoder_locked;
		logic pll_locked;
		logic interp_mute;
	} adcfe_status_t;

	typedef struct packed {
		logic power_on;
		logic input_channel_select;
		logic clock_source_select;
		logic converter_source_select;
		logic [1:0] format;
		logic [1:0] deemphasis;
		logic [5:0] volume;
		logic [3:0] bass;
		logic [1:0] treble;
		logic [1:0] filter_mode;
		logic lock_mute_enable;
	} adcfe_ctrl_t;

endpackage : adcfe_pkg

// >>> rtl/adcfe_top.sv
`timescale 1ns/1ps
module adcfe_top #(
	parameter logic [5:0] DEV_ADDR = adcfe_pkg::DEV_ADDR_DEFAULT
) (
	input wire logic mclk, // System clock
	input wire logic sys_rst, // Synchronous reset, high
	input wire logic clk_en, // Freezes state when low
	input wire logic control_mode_strap, // High static, low serial
	input wire logic bus_clock_pin, // Bus clock from controller
	input wire logic bus_mode_line, // Bus mode / format bit 1
	input wire logic bus_data_line, // Bus data in / format bit 0
	input wire logic mute_pin, // Static soft mute request
	input wire logic input_channel_select, // Static channel pin
	input wire logic clock_source_select, // Static clock source pin
	input wire logic converter_source_select, // Static DAC source pin
	input wire adcfe_pkg::adcfe_status_t decoder_status, // Datapath status
	output logic bus_data_out, // Bus data driven on reads
	output logic bus_data_oe, // Bus data output enable
	output logic lock_status, // Lock status pin
	output logic emphasis_status_low, // Emphasis code bit 0
	output logic emphasis_status_high, // Emphasis code bit 1
	output logic static_mode, // Static control active
	output logic soft_mute_active, // Soft mute request to DSP
	output adcfe_pkg::adcfe_ctrl_t ctrl_out // Effective settings
);

	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++)
			r[i] = v[7-i];
		return r;
	endfunction : rev8

	function automatic logic [15:0] rev16(input logic [15:0] v);
		logic [15:0] r;
		r = '0;
		for (int i = 0; i < 16; i++)
			r[i] = v[15-i];
		return r;
	endfunction : rev16

	function automatic adcfe_pkg::adcfe_ctrl_t cfg_from(
		input logic [15:0] sys,
		input logic [15:0] snd
	);
		adcfe_pkg::adcfe_ctrl_t c;
		c.power_on = sys[adcfe_pkg::SYS_POWER_BIT];
		c.input_channel_select = sys[adcfe_pkg::SYS_CHAN_BIT];
		c.clock_source_select = sys[adcfe_pkg::SYS_CLK_BIT];
		c.converter_source_select = sys[adcfe_pkg::SYS_DAC_BIT];
		c.format = sys[adcfe_pkg::SYS_FMT_LSB +: 2];
		c.deemphasis = sys[adcfe_pkg::SYS_DEEM_LSB +: 2];
		c.volume = snd[adcfe_pkg::SND_VOL_LSB +: 6];
		c.bass = snd[adcfe_pkg::SND_BASS_LSB +: 4];
		c.treble = snd[adcfe_pkg::SND_TREB_LSB +: 2];
		c.filter_mode = snd[adcfe_pkg::SND_FILT_LSB +: 2];
		c.lock_mute_enable = snd[adcfe_pkg::SND_AUTO_BIT];
		return c;
	endfunction : cfg_from

	// Read lookup: {valid, word}
	function automatic logic [16:0] rd_lookup(
		input logic [6:0] a,
		input logic [15:0] sys,
		input logic [15:0] snd,
		input logic [15:0] init,
		input logic [15:0] stat
	);
		logic [16:0] r;
		r = {1'b0, 16'h0000};
		if (a == adcfe_pkg::REG_SYSTEM)
			r = {1'b1, sys};
		else if (a == adcfe_pkg::REG_SOUND)
			r = {1'b1, snd};
		else if (a == adcfe_pkg::REG_STATUS)
			r = {1'b1, stat};
		else if (a == adcfe_pkg::REG_PLL_INIT)
			r = {1'b1, init};
		return r;
	endfunction : rd_lookup

	logic [7:0] pins_s;
	logic clk_q_reg;
	logic mode_q_reg;
	logic awake_reg;
	logic static_mode_reg;
	logic [4:0] cnt_reg;
	logic [15:0] rx_reg;
	adcfe_pkg::adcfe_sel_t sel_reg;
	adcfe_pkg::adcfe_sel_t sel_next;
	logic [6:0] wr_addr_reg;
	logic wr_dir_reg;
	logic [6:0] rd_addr_reg;
	logic rd_pend_reg;
	logic [23:0] tx_reg;
	logic [15:0] sys_reg;
	logic [15:0] snd_reg;
	logic [15:0] init_reg;
	logic [adcfe_pkg::SYNC_STAGES:0] warm_reg;

	adcfe_pin_sync #(
		.WIDTH(8)
	) u_sync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.pin_in({converter_source_select, clock_source_select,
			input_channel_select, mute_pin, control_mode_strap,
			bus_data_line, bus_mode_line, bus_clock_pin}),
		.pin_sync(pins_s)
	);

	wire clk_s = pins_s[0];
	wire mode_s = pins_s[1];
	wire data_s = pins_s[2];
	wire strap_s = pins_s[3];
	wire mute_s = pins_s[4];
	wire chan_s = pins_s[5];
	wire clks_s = pins_s[6];
	wire dacs_s = pins_s[7];

	// Synchroniser reset level is not the pin level: no clock edges until primed
	wire warm = warm_reg[adcfe_pkg::SYNC_STAGES];
	wire clk_rise = warm & clk_s & ~clk_q_reg;
	wire clk_fall = warm & ~clk_s & clk_q_reg;
	wire mode_change = mode_s ^ mode_q_reg;
	wire bus_on = ~static_mode_reg & awake_reg;
	wire bit_take = bus_on & clk_rise & ~mode_change;
	wire [15:0] rx_next = {data_s, rx_reg[15:1]};

	// Address phase decode
	wire addr_done = bit_take & ~mode_s
		& (cnt_reg == adcfe_pkg::LAST_BYTE_BIT);
	wire [7:0] addr_byte = rx_next[15:8];
	wire addr_match = addr_byte[7:2] == DEV_ADDR;
	wire [1:0] xfer_type = addr_byte[1:0];
	wire in_write = mode_s & (sel_reg == adcfe_pkg::SEL_WRITE);
	wire in_read = bus_on & mode_s & (sel_reg == adcfe_pkg::SEL_READ);

	// Data phase decode
	wire regb_done = bit_take & in_write
		& (cnt_reg == adcfe_pkg::LAST_BYTE_BIT);
	wire [7:0] regb_rev = rev8(rx_next[15:8]);
	wire word_done = bit_take & in_write & ~wr_dir_reg
		& (cnt_reg == adcfe_pkg::LAST_DATA_BIT);
	wire [15:0] wr_word = rev16(rx_next);
	wire wr_sys = word_done & (wr_addr_reg == adcfe_pkg::REG_SYSTEM);
	wire wr_snd = word_done & (wr_addr_reg == adcfe_pkg::REG_SOUND);
	wire wr_init = word_done & (wr_addr_reg == adcfe_pkg::REG_PLL_INIT);
	wire wr_restore = word_done & (wr_addr_reg == adcfe_pkg::REG_RESTORE);

	// Read data for the answer
	wire [15:0] status_word = {6'h00, decoder_status};
	wire [16:0] rd_hit = rd_lookup(rd_addr_reg, sys_reg, snd_reg, init_reg,
		status_word);
	wire rd_ok = rd_pend_reg & rd_hit[16];
	wire [15:0] rd_word = rd_ok ? rd_hit[15:0] : 16'h0000;
	wire [7:0] rd_regb = rev8({~rd_ok, rd_addr_reg});
	wire tx_shift = in_read & clk_fall & (cnt_reg != 5'h00);

	// Effective settings
	wire adcfe_pkg::adcfe_ctrl_t cfg_serial = cfg_from(sys_reg, snd_reg);
	wire adcfe_pkg::adcfe_ctrl_t cfg_dflt = cfg_from(adcfe_pkg::SYSTEM_RESET,
		adcfe_pkg::SOUND_RESET);
	wire adcfe_pkg::adcfe_ctrl_t cfg_static = '{
		power_on: cfg_dflt.power_on,
		input_channel_select: chan_s,
		clock_source_select: clks_s,
		converter_source_select: dacs_s,
		format: {mode_s, data_s},
		deemphasis: cfg_dflt.deemphasis,
		volume: cfg_dflt.volume,
		bass: cfg_dflt.bass,
		treble: cfg_dflt.treble,
		filter_mode: cfg_dflt.filter_mode,
		lock_mute_enable: cfg_dflt.lock_mute_enable
	};
	wire lock_static = decoder_status.pll_locked
		& decoder_status.decoder_locked & decoder_status.pcm_detected;
	wire lock_serial = decoder_status.pll_locked
		& decoder_status.decoder_locked;
	wire mute_next = static_mode_reg ? mute_s
		: snd_reg[adcfe_pkg::SND_MUTE_BIT];

	always_comb
	begin
		sel_next = sel_reg;
		if (mode_change & ~mode_s)
			sel_next = adcfe_pkg::SEL_NONE;
		else if (addr_done & addr_match & (xfer_type == adcfe_pkg::XFER_WRITE))
			sel_next = adcfe_pkg::SEL_WRITE;
		else if (addr_done & addr_match & (xfer_type == adcfe_pkg::XFER_READ))
			sel_next = adcfe_pkg::SEL_READ;
		else if (addr_done)
			sel_next = adcfe_pkg::SEL_NONE;
	end

	// Strap follows the pin, modes exclusive
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			static_mode_reg <= 1'b0;
		else if (clk_en)
			static_mode_reg <= strap_s;
	end

	// Filled with ones once the synchroniser carries real pin levels
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			warm_reg <= '0;
		else if (clk_en)
			warm_reg <= {warm_reg[adcfe_pkg::SYNC_STAGES-1:0], 1'b1};
	end

	// First clock pulse only wakes the interface
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			awake_reg <= 1'b0;
		else if (clk_en & clk_rise & ~static_mode_reg)
			awake_reg <= 1'b1;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			clk_q_reg <= 1'b0;
			mode_q_reg <= 1'b0;
			cnt_reg <= 5'h00;
			rx_reg <= 16'h0000;
			sel_reg <= adcfe_pkg::SEL_NONE;
		end
		else if (clk_en)
		begin
			clk_q_reg <= clk_s;
			mode_q_reg <= mode_s;
			sel_reg <= sel_next;
			if (mode_change)
				cnt_reg <= 5'h00;
			else if (bit_take & (cnt_reg != adcfe_pkg::CNT_MAX))
				cnt_reg <= cnt_reg + 5'h01;
			if (bit_take)
				rx_reg <= rx_next;
		end
	end

	// Register byte capture, prepare read
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			wr_addr_reg <= 7'h00;
			wr_dir_reg <= 1'b0;
			rd_addr_reg <= 7'h00;
			rd_pend_reg <= 1'b0;
		end
		else if (clk_en & regb_done)
		begin
			wr_addr_reg <= regb_rev[6:0];
			wr_dir_reg <= regb_rev[7];
			if (regb_rev[7])
			begin
				rd_addr_reg <= regb_rev[6:0];
				rd_pend_reg <= 1'b1;
			end
		end
	end

	// Answer shifter, first bit sits in bit 0
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			tx_reg <= 24'h000000;
		else if (clk_en & addr_done & addr_match
			& (xfer_type == adcfe_pkg::XFER_READ))
			tx_reg <= {rev16(rd_word), rd_regb};
		else if (clk_en & tx_shift)
			tx_reg <= {1'b0, tx_reg[23:1]};
	end

	// Control registers
	always_ff @(posedge mclk)
	begin
		if (sys_rst | (clk_en & wr_restore))
		begin
			sys_reg <= adcfe_pkg::SYSTEM_RESET;
			snd_reg <= adcfe_pkg::SOUND_RESET;
			init_reg <= adcfe_pkg::PLL_INIT_RESET;
		end
		else if (clk_en)
		begin
			if (wr_sys)
				sys_reg <= wr_word;
			if (wr_snd)
				snd_reg <= wr_word;
			if (wr_init)
				init_reg <= wr_word;
		end
	end

	// Registered outputs
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			bus_data_out <= 1'b0;
			bus_data_oe <= 1'b0;
			lock_status <= 1'b0;
			emphasis_status_low <= 1'b0;
			emphasis_status_high <= 1'b0;
			static_mode <= 1'b0;
			soft_mute_active <= 1'b1;
			ctrl_out <= cfg_from(adcfe_pkg::SYSTEM_RESET,
				adcfe_pkg::SOUND_RESET);
		end
		else if (clk_en)
		begin
			bus_data_out <= in_read & tx_reg[0];
			bus_data_oe <= in_read;
			lock_status <= static_mode_reg ? lock_static : lock_serial;
			emphasis_status_low <= decoder_status.emphasis[0];
			emphasis_status_high <= decoder_status.emphasis[1];
			static_mode <= static_mode_reg;
			soft_mute_active <= mute_next;
			ctrl_out <= static_mode_reg ? cfg_static : cfg_serial;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst || !clk_en);

	a_static_mode_on: assert property (
		strap_s [*2] |=> static_mode)
		else $error("static mode not entered");
	a_serial_mode_on: assert property (
		!strap_s [*2] |=> !static_mode)
		else $error("serial mode not entered");
	a_static_dflt_vol: assert property (
		static_mode_reg |=> ctrl_out.volume
			== adcfe_pkg::SOUND_RESET[adcfe_pkg::SND_VOL_LSB +: 6])
		else $error("static volume not default");
	a_static_format: assert property (
		static_mode_reg |=> ctrl_out.format == $past({mode_s, data_s}))
		else $error("static format wrong");
	a_static_chan: assert property (
		static_mode_reg |=> ctrl_out.input_channel_select == $past(chan_s))
		else $error("static channel wrong");
	a_lock_static: assert property (
		static_mode_reg |=> lock_status == $past(lock_static))
		else $error("static lock wrong");
	a_lock_serial: assert property (
		!static_mode_reg |=> lock_status == $past(lock_serial))
		else $error("serial lock wrong");
	a_emph_pins: assert property (
		1'b1 |=> {emphasis_status_high, emphasis_status_low}
			== $past(decoder_status.emphasis))
		else $error("emphasis pins wrong");
	a_serial_mute: assert property (
		!static_mode_reg && snd_reg[adcfe_pkg::SND_MUTE_BIT]
			|=> soft_mute_active)
		else $error("serial start-up not muted");
	a_read_select: assert property (
		addr_done && addr_match && xfer_type == adcfe_pkg::XFER_READ
			|=> sel_reg == adcfe_pkg::SEL_READ)
		else $error("read select missed");
	a_read_drive: assert property (
		in_read ##1 in_read |=> bus_data_oe)
		else $error("read data not driven");
	a_sound_write: assert property (
		wr_snd |=> snd_reg == $past(wr_word))
		else $error("sound write lost");
	a_reset_dflt: assert property (
		@(posedge mclk) disable iff (1'b0)
		sys_rst |=> snd_reg == adcfe_pkg::SOUND_RESET
			&& sys_reg == adcfe_pkg::SYSTEM_RESET)
		else $error("reset defaults wrong");

	c_write_word: cover property (word_done);
	c_read_phase: cover property (in_read ##1 tx_shift);
	c_prepare_read: cover property (regb_done && regb_rev[7]);
	c_static_mute: cover property (static_mode_reg && mute_s);

endmodule : adcfe_top
